// ==== core/adc_select_map.svh ====
// Register offsets, field positions and reset values of the input selector
`ifndef ADC_SELECT_MAP_SVH
`define ADC_SELECT_MAP_SVH
`define OFS_CH0_SELECT    8'h00
`define OFS_SCAN_HIGH     8'h04
`define OFS_SCAN_LOW      8'h08
`define OFS_CONTROL       8'h0c
`define OFS_STATUS        8'h10
`define CH0_WRITE_MASK    16'hbfbf
`define CH0_NEG_B_BIT     15
`define CH0_POS_B_LSB     8
`define CH0_NEG_A_BIT     7
`define CH0_POS_A_LSB     0
`define CTL_ALT_BIT       0
`define CTL_SCAN_BIT      1
`define CTL_RES10_BIT     2
`define CTL_REF_LSB       3
`define CTL_WRITE_MASK    16'h003f
`define REG_RESET         16'h0000
`define CODE_UNCONNECTED  6'h3f
`define CODE_TEMPERATURE  6'h3e
`define CODE_LAST_INPUT   6'h31
`define CODE_FIRST_WIDE   6'h20
`define SCAN_OA1_BIT      5'h18
`define SCAN_OA2_BIT      5'h19
`define SCAN_OA3_BIT      5'h1a
`define CODE_OA2          6'h00
`define CODE_OA1          6'h03
`define CODE_OA3          6'h06
`define CODE_OA5          6'h19
`endif

// ==== core/adc_select_pkg.sv ====
// Types shared by the channel 0 input selector
package adc_select_pkg;
    typedef enum logic [2:0] {
        src_pin          = 3'h0,
        src_op_amp       = 3'h1,
        src_temperature  = 3'h3,
        src_unconnected  = 3'h2,
        src_low_ref      = 3'h6
    } pos_source_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    typedef struct packed {
        logic [5:0]  pos_code;
        pos_source_t pos_src;
        logic        neg_to_input1;
        logic        neg_ext_ref;
        logic        phase_b;
    } mux_sel_t;

    typedef struct packed {
        logic [15:0] ch0_select;
        logic [15:0] scan_high;
        logic [15:0] scan_low;
        logic [15:0] control;
        logic [4:0]  scan_idx;
        logic        phase_b;
        logic [15:0] rdata;
        mux_sel_t    sel;
    } state_t;
endpackage

// ==== core/adc_input_select_scan.sv ====
// Channel 0 input selector with alternate sampling and input scan
`include "adc_select_map.svh"
module adc_input_select_scan #(
    parameter bit SECOND_UNIT = 1'b0
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic [7:0]               addr,
    input  wire logic [15:0]              wdata,
    input  wire logic                     wr,
    input  wire logic                     rd,
    output logic      [15:0]              rdata,
    input  wire logic                     sample_done,
    input  wire logic [5:1]               op_amp_mode_bit,
    output adc_select_pkg::mux_sel_t      sel
);
    adc_select_pkg::state_t   state;
    adc_select_pkg::state_t   next_state;
    adc_select_pkg::bus_req_t req;
    logic [31:0]              mask;
    logic [5:0]               pos_a;
    logic [5:0]               pos_b;
    logic [5:0]               cur_code;
    logic                     cur_neg;
    logic                     cur_b;

    // Scan slot to input code; op amp slots land on the shared pins
    function automatic logic [5:0] scan_code(input logic [4:0] idx);
        case (idx)
            `SCAN_OA1_BIT: scan_code = `CODE_OA1;
            `SCAN_OA2_BIT: scan_code = `CODE_OA2;
            `SCAN_OA3_BIT: scan_code = `CODE_OA3;
            default:       scan_code = {1'b0, idx};
        endcase
    endfunction

    // Next set mask bit above idx, else lowest set bit
    function automatic logic [4:0] next_scan(input logic [31:0] m,
                                             input logic [4:0]  idx);
        logic [4:0] first;
        logic [4:0] above;
        logic       got_first;
        logic       got_above;
        first = 5'h00;
        above = 5'h00;
        got_first = 1'b0;
        got_above = 1'b0;
        for (int i = 0; i < 32; i++) begin
            if (m[i] && !got_first) begin
                first = 5'(i);
                got_first = 1'b1;
            end
            if (m[i] && !got_above && 5'(i) > idx) begin
                above = 5'(i);
                got_above = 1'b1;
            end
        end
        next_scan = got_above ? above : first;
    endfunction

    // Where a positive code really connects
    function automatic adc_select_pkg::pos_source_t decode(input logic [5:0] code,
                                                          input logic [5:1] opm,
                                                          input logic       res10);
        if (code == `CODE_UNCONNECTED) begin
            decode = adc_select_pkg::src_unconnected;
        end else if (code == `CODE_TEMPERATURE) begin
            decode = adc_select_pkg::src_temperature;
        end else if (code > `CODE_LAST_INPUT) begin
            decode = adc_select_pkg::src_low_ref;
        end else if (code >= `CODE_FIRST_WIDE && (SECOND_UNIT || !res10)) begin
            decode = adc_select_pkg::src_low_ref;
        end else if ((code == `CODE_OA1 && opm[1]) || (code == `CODE_OA2 && opm[2])
                     || (code == `CODE_OA3 && opm[3]) || (code == `CODE_OA5 && opm[5])) begin
            decode = adc_select_pkg::src_op_amp;
        end else begin
            decode = adc_select_pkg::src_pin;
        end
    endfunction

    // Gather the bus request and the decoded fields
    always_comb begin
        req.addr  = addr;
        req.wdata = wdata;
        req.wr    = wr;
        req.rd    = rd;
        mask  = {state.scan_high, state.scan_low};
        pos_b = state.ch0_select[`CH0_POS_B_LSB +: 6];
        pos_a = state.ch0_select[`CH0_POS_A_LSB +: 6];
        cur_b = state.control[`CTL_ALT_BIT] && state.phase_b;
        cur_neg = cur_b ? state.ch0_select[`CH0_NEG_B_BIT]
                        : state.ch0_select[`CH0_NEG_A_BIT];
        if (state.control[`CTL_SCAN_BIT] && mask != 32'h0000_0000) begin
            cur_code = scan_code(state.scan_idx);
        end else begin
            cur_code = cur_b ? pos_b : pos_a;
        end
    end

    // Next state: register writes, reads, sequencing and outputs
    always_comb begin
        next_state = state;
        next_state.rdata = 16'h0000;
        if (req.wr) begin
            case (req.addr)
                `OFS_CH0_SELECT: next_state.ch0_select = req.wdata & `CH0_WRITE_MASK;
                `OFS_SCAN_HIGH:  next_state.scan_high = req.wdata;
                `OFS_SCAN_LOW:   next_state.scan_low = req.wdata;
                `OFS_CONTROL:    next_state.control = req.wdata & `CTL_WRITE_MASK;
                default:         next_state.ch0_select = state.ch0_select;
            endcase
        end
        if (req.rd) begin
            case (req.addr)
                `OFS_CH0_SELECT: next_state.rdata = state.ch0_select;
                `OFS_SCAN_HIGH:  next_state.rdata = state.scan_high;
                `OFS_SCAN_LOW:   next_state.rdata = state.scan_low;
                `OFS_CONTROL:    next_state.rdata = state.control;
                `OFS_STATUS:     next_state.rdata = {3'h0, state.scan_idx, 1'b0,
                                                     cur_b, cur_code};
                default:         next_state.rdata = 16'h0000;
            endcase
        end
        // Sample completion advances the alternation and the scan
        if (!state.control[`CTL_ALT_BIT]) begin
            next_state.phase_b = 1'b0;
        end else if (sample_done) begin
            next_state.phase_b = !state.phase_b;
        end
        if (!state.control[`CTL_SCAN_BIT]) begin
            next_state.scan_idx = next_scan(mask, 5'h1f);
        end else if (sample_done || !mask[state.scan_idx]) begin
            next_state.scan_idx = next_scan(mask, state.scan_idx);
        end
        next_state.sel.pos_code = cur_code;
        next_state.sel.pos_src = decode(cur_code, op_amp_mode_bit,
                                        state.control[`CTL_RES10_BIT]);
        next_state.sel.neg_to_input1 = cur_neg;
        next_state.sel.neg_ext_ref = state.control[`CTL_REF_LSB + 1] &&
                                     !state.control[`CTL_REF_LSB + 2];
        next_state.sel.phase_b = cur_b;
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rdata = state.rdata;
    assign sel   = state.sel;
endmodule

// ==== tb/adc_core_model.sv ====
// Conversion core stand-in that reports finished samples
module adc_core_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic start,
    input  wire logic slow,
    output logic      sample_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    // Countdown per sample, slow mode stretches it
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= 4'h0;
            sample_done <= 1'b0;
        end else begin
            sample_done <= (cnt == 4'h1);
            if (start) cnt <= slow ? 4'h6 : 4'h2;
            else if (cnt != 4'h0) cnt <= cnt - 4'h1;
        end
    end
endmodule

// ==== tb/adc_input_select_scan_assertions.sv ====
// Port checker for the channel 0 input selector
module adc_input_select_scan_assertions (
    input wire logic                     clk,
    input wire logic                     rst,
    input wire logic [7:0]               addr,
    input wire logic                     rd,
    input wire logic [15:0]              rdata,
    input wire logic                     sample_done,
    input wire logic [5:1]               op_amp_mode_bit,
    input wire adc_select_pkg::mux_sel_t sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_ch0_read;
        rd && addr == 8'h00;
    endsequence
    property p_idle_rdata; !$past(rd) |-> rdata == 16'h0000; endproperty
    property p_gap_bits; s_ch0_read |=> rdata[14] == 1'b0 && rdata[6] == 1'b0; endproperty
    property p_unconn; sel.pos_code == 6'h3f |-> sel.pos_src == adc_select_pkg::src_unconnected;
    endproperty
    property p_temp; sel.pos_code == 6'h3e |-> sel.pos_src == adc_select_pkg::src_temperature;
    endproperty
    property p_reserved; sel.pos_code inside {[6'h32:6'h3d]} |->
        sel.pos_src == adc_select_pkg::src_low_ref; endproperty
    property p_opamp; sel.pos_code == 6'h03 && $past(op_amp_mode_bit[1]) && !$past(rst) |->
        sel.pos_src == adc_select_pkg::src_op_amp; endproperty
    property p_pin; sel.pos_code inside {6'h01, 6'h02} |-> sel.pos_src == adc_select_pkg::src_pin;
    endproperty
    property p_phase; $rose(sel.phase_b) |-> $past(sample_done, 2); endproperty
    a_idle_rdata: assert property (p_idle_rdata) else $error("rdata not zero");
    a_gap_bits: assert property (p_gap_bits) else $error("gap bits set");
    a_unconn: assert property (p_unconn) else $error("code 3f source");
    a_temp: assert property (p_temp) else $error("code 3e source");
    a_reserved: assert property (p_reserved) else $error("reserved source");
    a_opamp: assert property (p_opamp) else $error("op amp source");
    a_pin: assert property (p_pin) else $error("pin source");
    a_phase: assert property (p_phase) else $error("phase without sample");
endmodule
bind adc_input_select_scan adc_input_select_scan_assertions i_chk (.clk(clk), .rst(rst),
    .addr(addr), .rd(rd), .rdata(rdata), .sample_done(sample_done),
    .op_amp_mode_bit(op_amp_mode_bit), .sel(sel));

// ==== tb/adc_input_select_scan_tb.sv ====
// Self-checking bench for the channel 0 input selector
module adc_input_select_scan_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, wr = 0, rd = 0, start = 0, slow = 0, sample_done;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [5:1] opm = 5'h00;
    adc_select_pkg::mux_sel_t sel;
    int fails = 0, total_checks = 0;
    initial forever #4 clk = ~clk;
    adc_input_select_scan i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .sample_done(sample_done), .op_amp_mode_bit(opm), .sel(sel));
    adc_core_model i_core (.clk(clk), .rst(rst), .start(start), .slow(slow),
        .sample_done(sample_done));
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function logic [15:0] s(logic [5:0] c, adc_select_pkg::pos_source_t k, logic n, e, p);
        return {4'h0, c, k, n, e, p};
    endfunction
    task wreg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk) wr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task rreg(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk) {rd, addr} <= {1'b1, a};
        @(posedge clk) rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task step;
        int i;
        @(posedge clk) start <= 1'b1;
        @(posedge clk) start <= 1'b0;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            #1;
            if (sample_done === 1'b1) break;
        end
        if (i == 20) begin
            fails++;
            final_report();
        end
        repeat (2) @(posedge clk);
        #1;
    endtask
    task t_reset_and_gaps;
        // Every mapped register, status and one unmapped offset read zero
        for (int i = 0; i < 6; i++) rreg(8'(4 * i), 16'h0000);
        wreg(8'h00, 16'hffff);
        rreg(8'h00, 16'hbfbf);
        chk(16'(sel), s(6'h3f, adc_select_pkg::src_unconnected, 1, 0, 0));
        wreg(8'h00, 16'h003e);
        chk(16'(sel), s(6'h3e, adc_select_pkg::src_temperature, 0, 0, 0));
    endtask
    task t_alternate;
        wreg(8'h00, 16'h3181);
        wreg(8'h0c, 16'h0001);
        chk(16'(sel), s(6'h01, adc_select_pkg::src_pin, 1, 0, 0));
        step();
        chk(16'(sel), s(6'h31, adc_select_pkg::src_low_ref, 0, 0, 1));
        wreg(8'h0c, 16'h0015);
        chk(16'(sel), s(6'h31, adc_select_pkg::src_pin, 0, 1, 1));
        @(posedge clk) slow <= 1'b1;
        step();
        chk(16'(sel), s(6'h01, adc_select_pkg::src_pin, 1, 1, 0));
        wreg(8'h0c, 16'h000d);
        chk(16'(sel), s(6'h01, adc_select_pkg::src_pin, 1, 0, 0));
    endtask
    task t_scan;
        @(posedge clk) opm <= 5'h01;
        wreg(8'h00, 16'h0000);
        wreg(8'h08, 16'h0006);
        wreg(8'h04, 16'h8100);
        rreg(8'h04, 16'h8100);
        wreg(8'h0c, 16'h0002);
        chk(16'(sel), s(6'h01, adc_select_pkg::src_pin, 0, 0, 0));
        step();
        chk(16'(sel), s(6'h02, adc_select_pkg::src_pin, 0, 0, 0));
        step();
        chk(16'(sel), s(6'h03, adc_select_pkg::src_op_amp, 0, 0, 0));
        step();
        chk(16'(sel), s(6'h1f, adc_select_pkg::src_pin, 0, 0, 0));
        step();
        chk(16'(sel), s(6'h01, adc_select_pkg::src_pin, 0, 0, 0));
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset_and_gaps();
        t_alternate();
        t_scan();
        final_report();
    end
endmodule
